// ==== bus_partner.sv ====
// far side of the two wire bus: open drain pulls over pull-ups, with clock stretching
`timescale 1ns/1ns
module bus_partner
  import i2c_status_pkg::*;
(
  input wire logic clock_i,
  input wire logic scl_oe_i,
  output logic scl_line_o,
  output logic sda_line_o
);
  logic scl_pull_q = 1'b0;
  logic sda_pull_q = 1'b0;
  int stretch = 0;
  int hold_q = 0;
  // keeps scl low a few cycles after the block lets go, like a slow slave
  always @(posedge clock_i) begin
    if (scl_oe_i) hold_q <= stretch;
    else if (hold_q > 0) hold_q <= hold_q - 1;
  end
  // wired and: any party pulling wins, pull-ups otherwise
  assign scl_line_o = !(scl_oe_i || scl_pull_q || hold_q != 0);
  assign sda_line_o = !sda_pull_q;
  // releases sda first so that a start from a held bus is a restart, not a stop
  task automatic start_cond();
    @(posedge clock_i) sda_pull_q <= 1'b0;
    @(posedge clock_i) scl_pull_q <= 1'b0;
    repeat (3) @(posedge clock_i);
    sda_pull_q <= 1'b1;
    repeat (3) @(posedge clock_i);
    scl_pull_q <= 1'b1;
  endtask : start_cond
  // waits for scl high, since a running master may hold it low
  task automatic stop_cond();
    @(posedge clock_i) scl_pull_q <= 1'b0;
    for (int k = 0; k < 600 && !scl_line_o; k++) begin
      @(posedge clock_i);
      #1;
    end
    @(posedge clock_i) sda_pull_q <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask : stop_cond
endmodule : bus_partner

// ==== i2c_status_irq_clock_gen.sv ====
// bus state status, interrupt gating and master clock control of the two wire interface
`timescale 1ns/1ns
module i2c_status_irq_clock_gen
  import i2c_status_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  // read of the first status register, elsewhere in the interface
  input wire logic first_status_read_i,
  // bus lines, taken as synchronous
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic scl_tick_o,
  // events from the slave and master data path
  input wire logic addr_match_i,
  input wire logic second_address_match_i,
  input wire logic general_call_header_i,
  input wire logic addr_phase_done_i,
  input wire logic rw_bit_i,
  // flags held elsewhere in the interface
  input wire logic start_sent_flag_i,
  input wire logic addr_flag_i,
  input wire logic header_sent_flag_i,
  input wire logic stop_detected_flag_i,
  input wire logic byte_done_flag_i,
  input wire logic tx_empty_flag_i,
  input wire logic rx_full_flag_i,
  input wire logic halt_wakeup_flag_i,
  input wire logic bus_error_flag_i,
  input wire logic arbitration_lost_flag_i,
  input wire logic ack_failure_flag_i,
  input wire logic overrun_flag_i,
  // control and results
  output logic block_on_o,
  output logic general_call_answer_o,
  output logic addr_clear_o,
  output logic event_irq_o,
  output logic error_irq_o
);

  logic block_on_q;
  logic gc_answer_q;
  logic [7:0] div_low_q;
  logic [2:0] irq_en_q;
  logic fast_q;
  logic duty_q;
  logic [3:0] div_high_q;
  logic [5:0] rise_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic busy_q;
  logic second_match_q;
  logic general_call_q;
  logic sending_q;
  logic master_q;
  logic first_read_seen_q;
  logic addr_clear_q;
  logic [7:0] rd_data_q;
  logic stop_seen;
  logic start_seen;
  logic restart_seen;
  logic end_of_frame;
  logic [7:0] bus_state;
  logic [7:0] rd_mux;
  logic scl_low;
  logic buf_event;
  logic scl_run;

  // register write decode
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr_i && (addr_i == ofs);
  endfunction : wr_hit

  // control register, block enable acts as soft reset for the status bits except busy
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      block_on_q <= RST_CONTROL[BIT_BLOCK_ON];
      gc_answer_q <= RST_CONTROL[BIT_GC_ANSWER];
    end else if (ce_i && wr_hit(OFS_CONTROL)) begin
      block_on_q <= wr_data_i[BIT_BLOCK_ON];
      gc_answer_q <= wr_data_i[BIT_GC_ANSWER];
    end
  end

  // interrupt enables, upper bits reserved
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_en_q <= RST_IRQ_EN[2:0];
    end else if (ce_i && wr_hit(OFS_IRQ_EN)) begin
      irq_en_q <= wr_data_i[2:0];
    end
  end

  // divider and rise time; written freely, software keeps them still while running
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_low_q <= RST_DIV_LOW;
      fast_q <= RST_DIV_HIGH[BIT_FAST];
      duty_q <= RST_DIV_HIGH[BIT_DUTY];
      div_high_q <= RST_DIV_HIGH[3:0];
      rise_q <= RST_RISE;
    end else if (ce_i) begin
      if (wr_hit(OFS_DIV_LOW)) begin
        div_low_q <= wr_data_i;
      end
      if (wr_hit(OFS_DIV_HIGH)) begin
        fast_q <= wr_data_i[BIT_FAST];
        duty_q <= wr_data_i[BIT_DUTY];
        div_high_q <= wr_data_i[3:0];
      end
      if (wr_hit(OFS_RISE)) begin
        rise_q <= wr_data_i[5:0];
      end
    end
  end

  // previous line samples for edge detection on the bus
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else if (ce_i) begin
      scl_prev_q <= scl_i;
      sda_prev_q <= sda_i;
    end
  end

  // stop is sda rising with scl high; a start while busy is a repeated start
  assign stop_seen = scl_i && scl_prev_q && sda_i && !sda_prev_q;
  assign start_seen = scl_i && scl_prev_q && !sda_i && sda_prev_q;
  assign restart_seen = start_seen && busy_q;
  assign end_of_frame = stop_seen || restart_seen;

  // busy tracks the bus regardless of the block enable
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
    end else if (ce_i) begin
      if (stop_seen) begin
        busy_q <= 1'b0;
      end else if (!scl_i || !sda_i) begin
        busy_q <= 1'b1;
      end
    end
  end

  // which own address matched, slave side
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      second_match_q <= 1'b0;
    end else if (ce_i) begin
      if (!block_on_q || end_of_frame) begin
        second_match_q <= 1'b0;
      end else if (addr_match_i) begin
        second_match_q <= second_address_match_i;
      end
    end
  end

  // general call header seen while answering is on
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      general_call_q <= 1'b0;
    end else if (ce_i) begin
      if (!block_on_q || end_of_frame) begin
        general_call_q <= 1'b0;
      end else if (general_call_header_i && gc_answer_q) begin
        general_call_q <= 1'b1;
      end
    end
  end

  // direction of the data bytes, taken at the end of the address phase
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sending_q <= 1'b0;
    end else if (ce_i) begin
      if (!block_on_q || end_of_frame || arbitration_lost_flag_i) begin
        sending_q <= 1'b0;
      end else if (addr_phase_done_i) begin
        sending_q <= rw_bit_i;
      end
    end
  end

  // master role; arbitration loss drops back to slave with no software help
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      master_q <= 1'b0;
    end else if (ce_i) begin
      if (!block_on_q || stop_seen || arbitration_lost_flag_i) begin
        master_q <= 1'b0;
      end else if (start_sent_flag_i) begin
        master_q <= 1'b1;
      end
    end
  end

  // first status read arms the address clear; the next bus state read fires it and disarms
  // no flag sampling here, so an address flag set after the first read still clears
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_read_seen_q <= 1'b0;
      addr_clear_q <= 1'b0;
    end else if (ce_i) begin
      addr_clear_q <= rd_i && (addr_i == OFS_BUS_STATE) && first_read_seen_q;
      if (first_status_read_i) begin
        first_read_seen_q <= 1'b1;
      end else if (rd_i && (addr_i == OFS_BUS_STATE)) begin
        first_read_seen_q <= 1'b0;
      end
    end
  end

  // bus state status, reserved bits zero
  assign bus_state = {second_match_q, 2'b00, general_call_q, 1'b0, sending_q, busy_q, master_q};

  // read multiplexer, unmapped offsets read zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr_i)
      OFS_CONTROL: rd_mux = {1'b0, gc_answer_q, 5'h00, block_on_q};
      OFS_DIV_LOW: rd_mux = div_low_q;
      OFS_BUS_STATE: rd_mux = bus_state;
      OFS_IRQ_EN: rd_mux = {5'h00, irq_en_q};
      OFS_DIV_HIGH: rd_mux = {fast_q, duty_q, 2'b00, div_high_q};
      OFS_RISE: rd_mux = {2'b00, rise_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_q <= 8'h00;
    end else if (ce_i) begin
      rd_data_q <= rd_i ? rd_mux : 8'h00;
    end
  end

  // interrupt gating; combinational so halt wakeup needs no running clock
  assign buf_event = tx_empty_flag_i || rx_full_flag_i;
  assign event_irq_o = irq_en_q[BIT_EVT_IRQ] && (start_sent_flag_i || addr_flag_i
                       || header_sent_flag_i || stop_detected_flag_i
                       || (byte_done_flag_i && !buf_event)
                       || (irq_en_q[BIT_BUF_IRQ] && buf_event)
                       || halt_wakeup_flag_i);
  assign error_irq_o = irq_en_q[BIT_ERR_IRQ] && (bus_error_flag_i || arbitration_lost_flag_i
                       || ack_failure_flag_i || overrun_flag_i);

  // clock generation runs only as enabled master
  assign scl_run = block_on_q && master_q;

  scl_timer u_scl_timer (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .run_i(scl_run),
    .fast_i(fast_q),
    .duty_i(duty_q),
    .div_i({div_high_q, div_low_q}),
    .rise_i(rise_q),
    .scl_i(scl_i),
    .scl_low_o(scl_low),
    .scl_tick_o(scl_tick_o)
  );

  // open drain scl: drive low only
  assign scl_o = 1'b0;
  assign scl_oe_o = scl_low;
  assign rd_data_o = rd_data_q;
  assign block_on_o = block_on_q;
  assign general_call_answer_o = gc_answer_q;
  assign addr_clear_o = addr_clear_q;

endmodule : i2c_status_irq_clock_gen

// ==== i2c_status_irq_clock_gen_bench.sv ====
// self-checking bench for the status, interrupt and scl block
`timescale 1ns/1ns
module i2c_status_irq_clock_gen_bench
  import i2c_status_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] ev = 4'h0;
  logic sec = 1'b0;
  logic rw = 1'b0;
  logic [11:0] flg = 12'h000;
  logic [7:0] rd_data_o;
  logic scl_oe_o, scl_tick_o, block_on_o, gca_o, addr_clear_o, event_irq_o, error_irq_o;
  logic scl_w, sda_w;
  logic [7:0] d;
  int bad_count = 0;
  int checks = 0;
  int lo, hi;
  logic [7:0] ra[7] = '{8'h00, 8'h02, 8'h09, 8'h0a, 8'h0c, 8'h0d, 8'h05};
  logic [7:0] rv[7] = '{8'h00, 8'h0b, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
  logic [7:0] wv[7] = '{8'h41, 8'hff, 8'h00, 8'h07, 8'hcf, 8'h3f, 8'h00};
  logic [7:0] dh[4] = '{8'h01, 8'h80, 8'hc0, 8'h00};
  logic [7:0] dl[4] = '{8'h04, 8'h04, 8'h01, 8'h04};
  int elo[4] = '{260, 8, 16, 4};
  int ehi[4] = '{260, 4, 9, 7};
  i2c_status_irq_clock_gen dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .first_status_read_i(ev[3]), .scl_i(scl_w), .sda_i(sda_w), .scl_o(),
    .scl_oe_o(scl_oe_o), .scl_tick_o(scl_tick_o), .addr_match_i(ev[0]),
    .second_address_match_i(sec), .general_call_header_i(ev[1]),
    .addr_phase_done_i(ev[2]), .rw_bit_i(rw), .start_sent_flag_i(flg[0]),
    .addr_flag_i(flg[1]), .header_sent_flag_i(flg[2]), .stop_detected_flag_i(flg[3]),
    .byte_done_flag_i(flg[4]), .tx_empty_flag_i(flg[5]), .rx_full_flag_i(flg[6]),
    .halt_wakeup_flag_i(flg[7]), .bus_error_flag_i(flg[8]),
    .arbitration_lost_flag_i(flg[9]), .ack_failure_flag_i(flg[10]),
    .overrun_flag_i(flg[11]), .block_on_o(block_on_o), .general_call_answer_o(gca_o),
    .addr_clear_o(addr_clear_o), .event_irq_o(event_irq_o), .error_irq_o(error_irq_o)
  );
  bus_partner peer (.clock_i(clock_i), .scl_oe_i(scl_oe_o), .scl_line_o(scl_w),
    .sda_line_o(sda_w));
  // free running clock, 40 ns period
  initial begin
    forever #20 clock_i = ~clock_i;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic step();
    @(posedge clock_i);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    step();
    rd_i <= 1'b0;
    v = rd_data_o;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, d);
    chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, d});
  endtask : rchk
  task automatic pulse(input logic [3:0] m, input logic s);
    @(posedge clock_i);
    sec <= s;
    rw <= 1'b1;
    ev <= m;
    @(posedge clock_i);
    ev <= 4'h0;
  endtask : pulse
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // cuts a hang short well past the expected run length
  initial begin
    #1000000;
    bad_count++;
    $display("[FAIL] run expected end seen timeout");
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    // reset values, then all ones to expose reserved and read only bits
    for (int i = 0; i < 7; i++) rchk(ra[i], rv[i]);
    for (int i = 0; i < 7; i++) wr(ra[i], 8'hff);
    for (int i = 0; i < 7; i++) rchk(ra[i], wv[i]);
    @(posedge clock_i) ce_i <= 1'b0;
    wr(8'h0d, 8'h05);
    @(posedge clock_i) ce_i <= 1'b1;
    rchk(8'h0d, 8'h3f);
    wr(8'h00, 8'h00);
    wr(8'h0c, 8'h00);
    wr(8'h0b, 8'h00);
    wr(8'h02, 8'h0b);
    wr(8'h0d, 8'h02);
    // interrupt gates: each flag alone under three enable settings
    for (int e = 0; e < 3; e++) begin
      wr(8'h0a, e == 0 ? 8'h00 : e == 1 ? 8'h03 : 8'h07);
      for (int i = 0; i < 12; i++) begin
        @(posedge clock_i) flg <= 12'h001 << i;
        step();
        chk("event irq", 16'(i < 8 && e > 0 && (e == 2 || (i != 5 && i != 6))),
            {15'h0, event_irq_o});
        chk("error irq", 16'(i >= 8 && e > 0), {15'h0, error_irq_o});
      end
      @(posedge clock_i) flg <= 12'h000;
    end
    // busy tracks the lines with the block off
    peer.start_cond();
    rchk(8'h09, 8'h02);
    peer.stop_cond();
    rchk(8'h09, 8'h00);
    wr(8'h00, 8'h01);
    peer.start_cond();
    pulse(4'h2, 1'b0);
    rchk(8'h09, 8'h02);
    wr(8'h00, 8'h41);
    step();
    chk("gc answer", 16'h1, {15'h0, gca_o});
    pulse(4'h7, 1'b1);
    rchk(8'h09, 8'h96);
    peer.start_cond();
    rchk(8'h09, 8'h02);
    pulse(4'h7, 1'b0);
    @(posedge clock_i) flg <= 12'h001;
    rchk(8'h09, 8'h17);
    @(posedge clock_i) flg <= 12'h200;
    rchk(8'h09, 8'h12);
    @(posedge clock_i) flg <= 12'h001;
    pulse(4'h4, 1'b0);
    rchk(8'h09, 8'h17);
    @(posedge clock_i) flg <= 12'h000;
    peer.stop_cond();
    rchk(8'h09, 8'h00);
    peer.start_cond();
    pulse(4'h7, 1'b1);
    @(posedge clock_i) flg <= 12'h001;
    rchk(8'h09, 8'h97);
    @(posedge clock_i) flg <= 12'h000;
    wr(8'h00, 8'h00);
    rchk(8'h09, 8'h02);
    chk("block on", 16'h0, {15'h0, block_on_o});
    peer.stop_cond();
    // address clear only on a status read armed by a first status read
    rd(8'h09, d);
    chk("addr clear", 16'h0, {15'h0, addr_clear_o});
    pulse(4'h8, 1'b0);
    rd(8'h09, d);
    chk("addr clear", 16'h1, {15'h0, addr_clear_o});
    rd(8'h09, d);
    chk("addr clear", 16'h0, {15'h0, addr_clear_o});
    // phase lengths per mode; the last entry has the far side stretching
    for (int i = 0; i < 4; i++) begin
      wr(8'h0c, dh[i]);
      wr(8'h02, dl[i]);
      peer.stretch = (i == 3) ? 5 : 0;
      wr(8'h00, 8'h01);
      @(posedge clock_i) flg <= 12'h001;
      lo = 0;
      hi = 0;
      for (int k = 0; k < 100 && scl_oe_o !== 1'b1; k++) step();
      while (scl_oe_o === 1'b1 && lo < 5000) begin
        step();
        lo++;
      end
      while (scl_oe_o === 1'b0 && hi < 5000) begin
        step();
        hi++;
      end
      chk("scl low", 16'(elo[i]), 16'(lo));
      chk("scl high", 16'(ehi[i]), 16'(hi));
      @(posedge clock_i) flg <= 12'h000;
      wr(8'h00, 8'h00);
    end
    tally_and_finish();
  end
endmodule : i2c_status_irq_clock_gen_bench

// ==== i2c_status_pkg.sv ====
// constants, register map and shared timing function for the status and clock block
//
// Overview of operation
// - bit 7 shows second own address matched
// - bit 4 flags general call when answering
// - bit 2 loads address read/write bit
// - direction cleared by stop, restart, arbitration, disable
// - busy sets on low line, clears on stop
// - busy keeps tracking while block is off
// - master bit sets on start sent, clears on stop, arbitration, disable
// - status read after first status clears address
// - buffer enable gates empty and full interrupts
// - event enable gates start, address, stop events
// - halt wakeup raises event interrupt asynchronously
// - error enable gates the four error flags
// - twelve bit divider sets standard high, low
// - high register bit 7 selects fast mode
// - fast duty zero gives low twice high
// - fast duty one gives nine and sixteen
// - rise time field bounds the scl feedback
// - arbitration loss returns block to slave
package i2c_status_pkg;

  // register offsets on the plain port
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_DIV_LOW = 8'h02;
  localparam logic [7:0] OFS_BUS_STATE = 8'h09;
  localparam logic [7:0] OFS_IRQ_EN = 8'h0a;
  localparam logic [7:0] OFS_DIV_HIGH = 8'h0c;
  localparam logic [7:0] OFS_RISE = 8'h0d;

  // values after reset
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_DIV_LOW = 8'h0b;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [5:0] RST_RISE = 6'h02;

  // field positions
  localparam int BIT_BLOCK_ON = 0;
  localparam int BIT_GC_ANSWER = 6;
  localparam int BIT_SECOND_MATCH = 7;
  localparam int BIT_GENERAL_CALL = 4;
  localparam int BIT_SENDING = 2;
  localparam int BIT_BUSY = 1;
  localparam int BIT_MASTER = 0;
  localparam int BIT_BUF_IRQ = 2;
  localparam int BIT_EVT_IRQ = 1;
  localparam int BIT_ERR_IRQ = 0;
  localparam int BIT_FAST = 7;
  localparam int BIT_DUTY = 6;

  // phase multipliers of the divider
  localparam logic [4:0] MUL_ONE = 5'h01;
  localparam logic [4:0] MUL_TWO = 5'h02;
  localparam logic [4:0] MUL_NINE = 5'h09;
  localparam logic [4:0] MUL_SIXTEEN = 5'h10;

  // length of one scl phase in input clocks
  function automatic logic [15:0] phase_len(input logic fast, input logic duty,
                                            input logic [11:0] div, input logic is_low);
    logic [4:0] mul;
    mul = MUL_ONE;
    if (fast && duty) begin
      mul = is_low ? MUL_SIXTEEN : MUL_NINE;
    end else if (fast) begin
      mul = is_low ? MUL_TWO : MUL_ONE;
    end
    phase_len = 16'({4'h0, div} * {11'h000, mul});
  endfunction : phase_len

endpackage : i2c_status_pkg

// ==== i2c_status_props.sv ====
// concurrent checks on the register, interrupt and scl ports of the status block
`timescale 1ns/1ns
module i2c_status_props
  import i2c_status_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rd_data_o,
  input wire logic first_status_read_i,
  input wire logic scl_oe_o,
  input wire logic scl_tick_o,
  input wire logic start_sent_flag_i,
  input wire logic addr_flag_i,
  input wire logic header_sent_flag_i,
  input wire logic stop_detected_flag_i,
  input wire logic byte_done_flag_i,
  input wire logic tx_empty_flag_i,
  input wire logic rx_full_flag_i,
  input wire logic halt_wakeup_flag_i,
  input wire logic bus_error_flag_i,
  input wire logic arbitration_lost_flag_i,
  input wire logic ack_failure_flag_i,
  input wire logic overrun_flag_i,
  input wire logic block_on_o,
  input wire logic addr_clear_o,
  input wire logic event_irq_o,
  input wire logic error_irq_o
);
  logic [2:0] en_q;
  logic [11:0] div_q;
  logic [1:0] mode_q;
  logic [15:0] lo_q;
  logic [15:0] low_len;
  logic arm_q;
  logic ev_any;
  logic err_any;
  logic st_rd;
  // mirror of enables and divider, taken the way the block takes writes
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_q <= 3'h0;
      div_q <= 12'h00b;
      mode_q <= 2'h0;
    end else if (wr_i && ce_i) begin
      if (addr_i == 8'h0a) en_q <= wr_data_i[2:0];
      if (addr_i == 8'h02) div_q[7:0] <= wr_data_i;
      if (addr_i == 8'h0c) div_q[11:8] <= wr_data_i[3:0];
      if (addr_i == 8'h0c) mode_q <= wr_data_i[7:6];
    end
  end
  // disarm has priority so a stale arm never yields a second clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) arm_q <= 1'b0;
    else if (st_rd && arm_q) arm_q <= 1'b0;
    else if (first_status_read_i && ce_i) arm_q <= 1'b1;
  end
  // cycles of the current low phase seen so far
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) lo_q <= 16'h0;
    else lo_q <= scl_oe_o ? lo_q + 16'h1 : 16'h0;
  end
  assign st_rd = rd_i && ce_i && addr_i == 8'h09;
  assign low_len = {4'h0, div_q} * (!mode_q[1] ? 16'h1 : mode_q[0] ? 16'h10 : 16'h2);
  assign ev_any = start_sent_flag_i || addr_flag_i || header_sent_flag_i ||
                  stop_detected_flag_i || halt_wakeup_flag_i;
  assign err_any = bus_error_flag_i || arbitration_lost_flag_i || ack_failure_flag_i ||
                   overrun_flag_i;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence low_end;
    scl_oe_o ##1 !scl_oe_o;
  endsequence
  a_err_irq_gate:
    assert property (error_irq_o == (en_q[0] && err_any)) else $error("error irq gate wrong");
  a_evt_irq_raise:
    assert property (en_q[1] && ev_any |-> event_irq_o) else $error("event irq missing");
  a_buf_irq_raise:
    assert property (en_q[1] && en_q[2] && (tx_empty_flag_i || rx_full_flag_i) |-> event_irq_o)
    else $error("buffer irq missing");
  a_buf_irq_mask:
    assert property (!en_q[2] && !ev_any && !byte_done_flag_i |-> !event_irq_o)
    else $error("buffer irq not masked");
  a_evt_irq_off:
    assert property (en_q[2:1] == 2'b00 |-> !event_irq_o) else $error("event irq not off");
  a_clear_cause:
    assert property (addr_clear_o |-> $past(st_rd)) else $error("address clear without read");
  a_clear_armed:
    assert property (st_rd && arm_q |=> addr_clear_o) else $error("address clear missing");
  a_read_quiet:
    assert property (!$past(rd_i) |-> rd_data_o == 8'h00) else $error("read data outside slot");
  a_low_len:
    assert property (scl_tick_o |-> lo_q + 16'h1 == low_len) else $error("scl low length");
  a_tick_end:
    assert property (scl_tick_o |-> low_end) else $error("tick not at end of low");
  a_oe_needs_on:
    assert property (scl_oe_o |-> $past(block_on_o, 2)) else $error("scl driven while off");
endmodule : i2c_status_props

bind i2c_status_irq_clock_gen i2c_status_props u_props (.*);

// ==== scl_timer.sv ====
// master scl generator with rise time bounded feedback
`timescale 1ns/1ns
module scl_timer
  import i2c_status_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic fast_i,
  input wire logic duty_i,
  input wire logic [11:0] div_i,
  input wire logic [5:0] rise_i,
  input wire logic scl_i,
  output logic scl_low_o,
  output logic scl_tick_o
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b100
  } phase_e;

  phase_e state_q;
  logic [15:0] cnt_q;
  logic [15:0] low_len;
  logic [15:0] high_len;
  logic advance;

  // phase lengths from mode, duty and divider
  assign low_len = phase_len(fast_i, duty_i, div_i, 1'b1);
  assign high_len = phase_len(fast_i, duty_i, div_i, 1'b0);

  // high count runs during the rise window, then waits for the line to be high
  assign advance = scl_i || (cnt_q < {10'h000, rise_i});

  // phase sequencer; leaving run releases the line at once
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
    end else if (ce_i) begin
      if (!run_i) begin
        state_q <= ST_IDLE;
        cnt_q <= 16'h0000;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            state_q <= ST_LOW;
            cnt_q <= 16'h0000;
          end
          ST_LOW: begin
            if (cnt_q + 16'h0001 >= low_len) begin
              state_q <= ST_HIGH;
              cnt_q <= 16'h0000;
            end else begin
              cnt_q <= cnt_q + 16'h0001;
            end
          end
          ST_HIGH: begin
            if (advance) begin
              if (cnt_q + 16'h0001 >= high_len) begin
                state_q <= ST_LOW;
                cnt_q <= 16'h0000;
              end else begin
                cnt_q <= cnt_q + 16'h0001;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
          end
        endcase
      end
    end
  end

  // open drain drive and end of low phase marker
  assign scl_low_o = (state_q == ST_LOW);
  assign scl_tick_o = (state_q == ST_LOW) && (cnt_q + 16'h0001 >= low_len);

endmodule : scl_timer
